// ==== verilog/rtc_defs.svh ====
// Constants of the serial clock/calendar core
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define RTC_SLAVE_ADDR 7'h68
`define RTC_MEM_DEPTH 32
`define RTC_TIME_BYTES 8
`define RTC_CTRL_ADDR 5'h08
`define RTC_ALM1_BASE 5'h0a
`define RTC_FLAG_ADDR 5'h0f
`define RTC_SQUARE_ADDR 5'h13
`define RTC_ALM2_BASE 5'h14
`define RTC_OUT_BIT 7
`define RTC_FT_BIT 6
`define RTC_AF1_BIT 6
`define RTC_AF2_BIT 5
`define RTC_AIE_BIT 7
`define RTC_SQUARE_EN_BIT 7
`define RTC_CTRL_RESET 8'h80
`define RTC_SQUARE_RESET 8'h80
`define RTC_DATE_RESET 8'h01
`define RTC_MONTH_RESET 8'h01
`define RTC_OSC_HZ 17'h0_8000
`define RTC_TICK_HZ 17'h0_0064
`define RTC_FT_DIV_BITS 6
`endif

// ==== verilog/rtc_pkg.sv ====
// Types of the serial clock/calendar core
`default_nettype none
package rtc_pkg;
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
		logic [7:0] hund;
	} rtc_time_s;

	typedef enum logic [2:0] {
		RTC_IDLE = 3'b000,
		RTC_ADDR = 3'b001,
		RTC_ADDR_ACK = 3'b010,
		RTC_RX = 3'b011,
		RTC_RX_ACK = 3'b100,
		RTC_TX = 3'b101,
		RTC_TX_ACK = 3'b110
	} rtc_state_e;
endpackage
`default_nettype wire

// ==== verilog/rtc_core.sv ====
// Serial two-wire real-time clock and calendar core
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_core (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic supply_ok_in,
	input wire logic oscillator_input_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic oscillator_output_out,
	output logic square_wave_output_out,
	output logic backup_mode_out,
	output logic power_on_reset_out,
	output logic power_on_reset_oe_out,
	output logic shared_irq_out_test_pin_out,
	output logic shared_irq_out_test_pin_oe_out,
	output logic shared_test_reset_pin_out,
	output logic shared_test_reset_pin_oe_out,
	output logic second_alarm_irq_output_out,
	output logic second_alarm_irq_output_oe_out
);
	import rtc_pkg::*;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = v + 8'h01;
		end
	endfunction

	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
			(yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
		case (mon)
			8'h02: month_days = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
			default: month_days = 8'h31;
		endcase
	endfunction

	// Bus side state
	rtc_state_e state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic [4:0] ptr, next_ptr;
	logic rw, next_rw;
	logic first, next_first;
	logic sda_oe, next_sda_oe;
	logic scl_q, sda_q;
	logic wr_en, snap, commit;

	// Timekeeping and register map
	logic [7:0] mem [0:`RTC_MEM_DEPTH-1];
	logic [7:0] next_mem [0:`RTC_MEM_DEPTH-1];
	rtc_time_s live, next_live;
	logic [16:0] acc, next_acc;
	logic [`RTC_FT_DIV_BITS-1:0] ft_div, next_ft_div;
	logic dirty, next_dirty;
	logic osc_q, osc_qq;
	logic osc_rise, tick;

	logic scl_rise, scl_fall, start_cond, stop_cond;
	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	assign start_cond = scl_in && scl_q && sda_q && !sda_in;
	assign stop_cond = scl_in && scl_q && !sda_q && sda_in;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_ptr = ptr;
		next_rw = rw;
		next_first = first;
		next_sda_oe = sda_oe;
		wr_en = 1'b0;
		snap = 1'b0;
		commit = 1'b0;
		if (!supply_ok_in) begin
			next_state = RTC_IDLE;
			next_ptr = 5'h00;
			next_sda_oe = 1'b0;
		end else if (start_cond) begin
			// A repeated start also lands pending time writes
			next_state = RTC_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
			commit = 1'b1;
		end else if (stop_cond) begin
			next_state = RTC_IDLE;
			next_sda_oe = 1'b0;
			commit = 1'b1;
		end else begin
			case (state)
				RTC_ADDR, RTC_RX: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_in};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						if (state == RTC_ADDR) begin
							if (shreg[7:1] == `RTC_SLAVE_ADDR) begin
								next_sda_oe = 1'b1;
								next_rw = shreg[0];
								next_first = !shreg[0];
								snap = 1'b1;
								next_state = RTC_ADDR_ACK;
							end else begin
								next_state = RTC_IDLE;
							end
						end else begin
							next_sda_oe = 1'b1;
							next_state = RTC_RX_ACK;
							if (first) begin
								next_ptr = shreg[4:0];
								next_first = 1'b0;
							end else begin
								wr_en = 1'b1;
								next_ptr = ptr + 5'h01;
							end
						end
					end
				end
				RTC_ADDR_ACK, RTC_TX_ACK: begin
					if (state == RTC_TX_ACK && scl_rise) begin
						if (!sda_in) begin
							next_ptr = ptr + 5'h01;
							next_first = 1'b1;
						end else begin
							next_first = 1'b0;
						end
					end else if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (rw && (state == RTC_ADDR_ACK || first)) begin
							next_state = RTC_TX;
							next_shreg = mem[ptr];
							next_sda_oe = !mem[ptr][7];
						end else if (rw) begin
							// Master ended the read; wait for stop
							next_state = RTC_IDLE;
						end else begin
							next_state = RTC_RX;
							next_sda_oe = 1'b0;
						end
					end
				end
				RTC_RX_ACK: begin
					if (scl_fall) begin
						next_sda_oe = 1'b0;
						next_bit_cnt = 4'h0;
						next_state = RTC_RX;
					end
				end
				RTC_TX: begin
					if (scl_fall) begin
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							next_sda_oe = 1'b0;
							next_state = RTC_TX_ACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_sda_oe = !shreg[6];
						end
					end
				end
				default: begin
					next_state = RTC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= RTC_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 5'h00;
			rw <= 1'b0;
			first <= 1'b0;
			sda_oe <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			ptr <= next_ptr;
			rw <= next_rw;
			first <= next_first;
			sda_oe <= next_sda_oe;
			// inputs ignored while supply is out
			scl_q <= supply_ok_in ? scl_in : 1'b1;
			sda_q <= supply_ok_in ? sda_in : 1'b1;
		end
	end

	// Alarm match on month/date/hour/minute/second bytes of a five-byte block
	function automatic logic alarm_hit(input logic [4:0] base, input rtc_time_s t);
		alarm_hit = mem[base][`RTC_AIE_BIT] && mem[base][4:0] == t.month[4:0] &&
			mem[base + 5'h1][5:0] == t.date[5:0] && mem[base + 5'h2][5:0] == t.hour[5:0] &&
			mem[base + 5'h3][6:0] == t.min[6:0] && mem[base + 5'h4][6:0] == t.sec[6:0];
	endfunction

	assign osc_rise = osc_q && !osc_qq;
	// fractional divide, 100 ticks per 32768 cycles
	assign tick = osc_rise && (acc + `RTC_TICK_HZ >= `RTC_OSC_HZ);

	always_comb begin
		rtc_time_s buf_t;
		logic [7:0] hr_inc;
		buf_t = live;
		hr_inc = bcd_inc({2'h0, live.hour[5:0]});
		next_live = live;
		next_acc = acc;
		next_ft_div = ft_div;
		next_dirty = dirty;
		for (int i = 0; i < `RTC_MEM_DEPTH; i++) begin
			next_mem[i] = mem[i];
		end
		for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
			buf_t[8*i +: 8] = mem[i];
		end
		if (osc_rise) begin
			next_ft_div = ft_div + 1'b1;
			next_acc = tick ? acc + `RTC_TICK_HZ - `RTC_OSC_HZ : acc + `RTC_TICK_HZ;
		end
		// counting carries on in backup mode
		if (tick) begin
			next_live.hund = (live.hund == 8'h99) ? 8'h00 : bcd_inc(live.hund);
			if (live.hund == 8'h99) begin
				next_live.sec = (live.sec == 8'h59) ? 8'h00 : bcd_inc(live.sec);
				if (live.sec == 8'h59) begin
					next_live.min = (live.min == 8'h59) ? 8'h00 : bcd_inc(live.min);
					if (live.min == 8'h59) begin
						if (live.hour[5:0] == 6'h23) begin
							next_live.hour = {live.hour[7:6], 6'h00};
							next_live.day = (live.day[2:0] == 3'h7) ? 8'h01 : live.day + 8'h01;
							if (live.date == month_days(live.month, live.year)) begin
								next_live.date = 8'h01;
								next_live.month = (live.month == 8'h12) ? 8'h01 : bcd_inc(live.month);
								if (live.month == 8'h12) begin
									next_live.year = (live.year == 8'h99) ? 8'h00 : bcd_inc(live.year);
									if (live.year == 8'h99) begin
										next_live.hour[7:6] = live.hour[7:6] + 2'h1;
									end
								end
							end else begin
								next_live.date = bcd_inc(live.date);
							end
						end else begin
							next_live.hour = {live.hour[7:6], hr_inc[5:0]};
						end
					end
				end
			end
		end
		// time written through the buffer lands at end of transfer
		if (commit && dirty) begin
			next_live = buf_t;
			next_dirty = 1'b0;
		end
		if (snap) begin
			for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
				next_mem[i] = live[8*i +: 8];
			end
		end
		// control bytes and user bytes are plain storage
		if (wr_en) begin
			next_mem[ptr] = shreg;
			if (ptr < `RTC_TIME_BYTES) begin
				next_dirty = 1'b1;
			end
		end
		// Flag set wins over a clearing write in the same cycle
		if (tick && next_live.hund == 8'h00 && alarm_hit(`RTC_ALM1_BASE, next_live)) begin
			next_mem[`RTC_FLAG_ADDR][`RTC_AF1_BIT] = 1'b1;
		end
		if (tick && next_live.hund == 8'h00 && alarm_hit(`RTC_ALM2_BASE, next_live)) begin
			next_mem[`RTC_FLAG_ADDR][`RTC_AF2_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < `RTC_MEM_DEPTH; i++) begin
				mem[i] <= 8'h00;
			end
			mem[`RTC_CTRL_ADDR] <= `RTC_CTRL_RESET;
			mem[`RTC_SQUARE_ADDR] <= `RTC_SQUARE_RESET;
			live <= '{year: 8'h00, month: `RTC_MONTH_RESET, date: `RTC_DATE_RESET, day: 8'h01,
				hour: 8'h00, min: 8'h00, sec: 8'h00, hund: 8'h00};
			acc <= 17'h0_0000;
			ft_div <= '0;
			dirty <= 1'b0;
			osc_q <= 1'b0;
			osc_qq <= 1'b0;
		end else begin
			for (int i = 0; i < `RTC_MEM_DEPTH; i++) begin
				mem[i] <= next_mem[i];
			end
			live <= next_live;
			acc <= next_acc;
			ft_div <= next_ft_div;
			dirty <= next_dirty;
			osc_q <= oscillator_input_in;
			osc_qq <= osc_q;
		end
	end

	// Registered pins
	logic ft_en, ft_low, irq1, out_bit;
	assign ft_en = mem[`RTC_CTRL_ADDR][`RTC_FT_BIT];
	assign ft_low = ft_en && !ft_div[`RTC_FT_DIV_BITS-1];
	assign out_bit = mem[`RTC_CTRL_ADDR][`RTC_OUT_BIT];
	assign irq1 = mem[`RTC_FLAG_ADDR][`RTC_AF1_BIT] && mem[`RTC_ALM1_BASE][`RTC_AIE_BIT];

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sda_oe_out <= 1'b0;
			sda_out <= 1'b0;
			oscillator_output_out <= 1'b0;
			square_wave_output_out <= 1'b0;
			backup_mode_out <= 1'b0;
			power_on_reset_oe_out <= 1'b1;
			shared_irq_out_test_pin_oe_out <= 1'b0;
			shared_test_reset_pin_oe_out <= 1'b1;
			second_alarm_irq_output_oe_out <= 1'b0;
		end else begin
			sda_oe_out <= sda_oe;
			sda_out <= 1'b0;
			oscillator_output_out <= !osc_q;
			square_wave_output_out <= osc_q && mem[`RTC_SQUARE_ADDR][`RTC_SQUARE_EN_BIT];
			backup_mode_out <= !supply_ok_in;
			power_on_reset_oe_out <= !supply_ok_in;
			// test beats interrupt beats output level
			shared_irq_out_test_pin_oe_out <= ft_en ? ft_low : (irq1 || !out_bit);
			shared_test_reset_pin_oe_out <= !supply_ok_in || ft_low;
			second_alarm_irq_output_oe_out <= mem[`RTC_FLAG_ADDR][`RTC_AF2_BIT] &&
				mem[`RTC_ALM2_BASE][`RTC_AIE_BIT];
		end
	end

	// Open-drain pins only ever pull low
	assign power_on_reset_out = sda_out;
	assign shared_irq_out_test_pin_out = sda_out;
	assign shared_test_reset_pin_out = sda_out;
	assign second_alarm_irq_output_out = sda_out;
endmodule
`default_nettype wire

// ==== tb/rtc_core_asserts.sv ====
// Port-level checks for the clock/calendar core
`timescale 1ns/10ps
`default_nettype none
module rtc_core_asserts (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic supply_ok_in,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic oscillator_output_out,
	input wire logic square_wave_output_out,
	input wire logic backup_mode_out,
	input wire logic power_on_reset_out,
	input wire logic power_on_reset_oe_out,
	input wire logic shared_irq_out_test_pin_out,
	input wire logic shared_test_reset_pin_out,
	input wire logic shared_test_reset_pin_oe_out,
	input wire logic second_alarm_irq_output_out
);
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic live;
	// Past values still show reset state for two edges after release
	always_comb begin
		next_settle = (settle == 2'h2) ? settle : settle + 2'h1;
	end
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			settle <= 2'h0;
		end else begin
			settle <= next_settle;
		end
	end
	assign live = (settle == 2'h2);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	sequence s_supply_gone;
		!supply_ok_in [*4];
	endsequence
	sequence s_quiet_supply;
		live && supply_ok_in && $past(supply_ok_in, 4);
	endsequence
	a_reset_output: assert property (live |-> power_on_reset_oe_out == !$past(supply_ok_in))
		else $error("reset output does not follow the supply");
	a_backup_mode: assert property (live |-> backup_mode_out == !$past(supply_ok_in))
		else $error("backup mode does not follow the supply");
	a_test_reset_pin: assert property (live && !$past(supply_ok_in) |-> shared_test_reset_pin_oe_out)
		else $error("shared test pin not pulled on supply loss");
	a_open_drain_low: assert property (!(sda_out | power_on_reset_out | shared_irq_out_test_pin_out
		| shared_test_reset_pin_out | second_alarm_irq_output_out))
		else $error("open drain pin drives high");
	a_release_on_loss: assert property (s_supply_gone |-> !sda_oe_out)
		else $error("data line held during supply loss");
	a_change_clock_low: assert property (s_quiet_supply ##0 $changed(sda_oe_out)
		|-> !scl_in && !$past(scl_in))
		else $error("data line changed while clock high");
	a_square_follows: assert property (live && supply_ok_in
		|-> square_wave_output_out != oscillator_output_out)
		else $error("square wave not running from the oscillator");
	a_loss_backup_release: assert property (live && $rose(power_on_reset_oe_out)
		|-> backup_mode_out ##[1:3] !sda_oe_out)
		else $error("supply loss did not free the bus");
endmodule
bind rtc_core rtc_core_asserts u_rtc_core_asserts (.*);
`default_nettype wire

// ==== tb/rtc_i2c_master.sv ====
// Two-wire bus master model driving the core's serial port
`timescale 1ns/10ps
`default_nettype none
module rtc_i2c_master (
	input wire logic clk_sys_in,
	input wire logic sda_in,
	output var logic scl_out,
	output var logic sda_pull_out
);
	// Half clock period in system clocks; the core needs at least 3
	int half = 6;
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Data moves only while the clock is low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		sda_pull_out <= !b;
		wait_clk(half);
		scl_out <= 1'b1;
		wait_clk(half);
		r = sda_in;
		scl_out <= 1'b0;
		wait_clk(2);
	endtask
	// start: data falls while the clock is high
	task automatic start_c;
		sda_pull_out <= 1'b0;
		wait_clk(half);
		scl_out <= 1'b1;
		wait_clk(half);
		sda_pull_out <= 1'b1;
		wait_clk(half);
		scl_out <= 1'b0;
		wait_clk(2);
	endtask
	task automatic stop_c;
		sda_pull_out <= 1'b1;
		wait_clk(half);
		scl_out <= 1'b1;
		wait_clk(half);
		sda_pull_out <= 1'b0;
		wait_clk(half);
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!ack, r);
	endtask
endmodule
`default_nettype wire

// ==== tb/serial_rtc_calendar_core_bench.sv ====
// Self-checking bench for the clock/calendar core
`timescale 1ns/10ps
`default_nettype none
`include "rtc_defs.svh"
module serial_rtc_calendar_core_bench;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic supply_ok_in = 1'b1;
	logic oscillator_input_in = 1'b0;
	wire logic scl_in, sda_in, sda_pull, sda_out, sda_oe_out, oscillator_output_out;
	wire logic square_wave_output_out, backup_mode_out, power_on_reset_out, power_on_reset_oe_out;
	wire logic shared_irq_out_test_pin_out, shared_irq_out_test_pin_oe_out;
	wire logic shared_test_reset_pin_out, shared_test_reset_pin_oe_out;
	wire logic second_alarm_irq_output_out, second_alarm_irq_output_oe_out;
	int fail_count = 0;
	int checked = 0;
	logic [7:0] buffer [0:31];
	logic ack;
	always #5 clk_sys_in = !clk_sys_in;
	// Pulled-up data line, low when either party pulls
	assign sda_in = !(sda_pull | sda_oe_out);
	rtc_core u_rtc_core (.*);
	rtc_i2c_master u_rtc_i2c_master (.clk_sys_in(clk_sys_in), .sda_in(sda_in),
		.scl_out(scl_in), .sda_pull_out(sda_pull));
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic exp_ack);
		u_rtc_i2c_master.put_byte(b, ack);
		check(ack, exp_ack);
	endtask
	task automatic wr(input logic [7:0] ptr, input int n);
		u_rtc_i2c_master.start_c();
		send(8'hd0, 1'b1);
		send(ptr, 1'b1);
		for (int i = 0; i < n; i++) send(buffer[i], 1'b1);
		u_rtc_i2c_master.stop_c();
	endtask
	// Pointer write, repeated start, last byte refused
	task automatic rd(input logic [7:0] ptr, input int n);
		u_rtc_i2c_master.start_c();
		send(8'hd0, 1'b1);
		send(ptr, 1'b1);
		u_rtc_i2c_master.start_c();
		send(8'hd1, 1'b1);
		for (int i = 0; i < n; i++) u_rtc_i2c_master.get_byte(i < n - 1, buffer[i]);
		u_rtc_i2c_master.stop_c();
	endtask
	task automatic osc_pulses(input int n);
		repeat (n) begin
			oscillator_input_in <= 1'b1;
			ticks(2);
			oscillator_input_in <= 1'b0;
			ticks(2);
		end
	endtask
	task automatic t_reset_map;
		rd(8'h00, 32);
		for (int i = 0; i < 32; i++) begin
			check(buffer[i], (i inside {4, 5, 6}) ? 8'h01 : (i == 8 || i == 19) ? 8'h80 : 8'h00);
		end
		check(second_alarm_irq_output_oe_out, 1'b0);
		check(shared_irq_out_test_pin_oe_out, 1'b0);
		$display("t_reset_map done");
	endtask
	task automatic t_square;
		oscillator_input_in <= 1'b1;
		ticks(6);
		check(square_wave_output_out, 1'b1);
		oscillator_input_in <= 1'b0;
		ticks(6);
		check(square_wave_output_out, 1'b0);
		$display("t_square done");
	endtask
	task automatic t_wrong_addr;
		u_rtc_i2c_master.start_c();
		send(8'hd2, 1'b0);
		u_rtc_i2c_master.stop_c();
		$display("t_wrong_addr done");
	endtask
	task automatic t_user_ram;
		for (int i = 0; i < 7; i++) buffer[i] = 8'h5a + 8'(i);
		u_rtc_i2c_master.half = 3;
		wr(8'h19, 7);
		u_rtc_i2c_master.half = 6;
		rd(8'h19, 7);
		for (int i = 0; i < 7; i++) check(buffer[i], 8'h5a + 8'(i));
		// Refused last byte leaves the pointer on 1Fh
		u_rtc_i2c_master.start_c();
		send(8'hd1, 1'b1);
		u_rtc_i2c_master.get_byte(1'b0, buffer[0]);
		u_rtc_i2c_master.stop_c();
		check(buffer[0], 8'h60);
		$display("t_user_ram done");
	endtask
	task automatic t_rollover;
		logic [31:0] set_v [0:4] = '{32'h0102_2807, 32'h0402_2803, 32'h0402_2903,
			32'h0104_3002, 32'h9912_3105};
		logic [39:0] exp_v [0:4] = '{40'h00_0103_0101, 40'h00_0402_2904, 40'h00_0403_0104,
			40'h00_0105_0103, 40'h40_0001_0106};
		for (int k = 0; k < 5; k++) begin
			{buffer[7], buffer[6], buffer[5], buffer[4]} = set_v[k];
			{buffer[3], buffer[2], buffer[1], buffer[0]} = 32'h2359_5999;
			wr(8'h00, 8);
			// 328 rises hold one or two hundredth ticks
			osc_pulses(328);
			rd(8'h00, 8);
			check(buffer[0] & 8'hfe, 8'h00);
			check({buffer[1], buffer[2]}, 16'h0000);
			check({buffer[3], buffer[7], buffer[6], buffer[5], buffer[4]}, exp_v[k]);
		end
		$display("t_rollover done");
	endtask
	task automatic t_supply_loss;
		u_rtc_i2c_master.start_c();
		send(8'hd0, 1'b1);
		send(8'h19, 1'b1);
		supply_ok_in <= 1'b0;
		ticks(4);
		check({backup_mode_out, power_on_reset_oe_out, shared_test_reset_pin_oe_out}, 3'h7);
		send(8'h77, 1'b0);
		u_rtc_i2c_master.stop_c();
		supply_ok_in <= 1'b1;
		ticks(4);
		check({backup_mode_out, power_on_reset_oe_out, shared_test_reset_pin_oe_out}, 3'h0);
		u_rtc_i2c_master.start_c();
		send(8'hd1, 1'b1);
		u_rtc_i2c_master.get_byte(1'b1, buffer[0]);
		u_rtc_i2c_master.get_byte(1'b0, buffer[1]);
		u_rtc_i2c_master.stop_c();
		check(buffer[1], 8'h00);
		rd(8'h19, 1);
		check(buffer[0], 8'h5a);
		$display("t_supply_loss done");
	endtask
	task automatic t_out_bit;
		buffer[0] = 8'h00;
		wr(8'h08, 1);
		ticks(3);
		check(shared_irq_out_test_pin_oe_out, 1'b1);
		buffer[0] = 8'h80;
		wr(8'h08, 1);
		ticks(3);
		check(shared_irq_out_test_pin_oe_out, 1'b0);
		$display("t_out_bit done");
	endtask
	// Both alarms armed for 00:00:10 on 1 January, clock set just before it
	task automatic t_alarm;
		{buffer[0], buffer[1], buffer[2], buffer[3], buffer[4]} = 40'h81_0100_0010;
		wr(8'h0a, 5);
		wr(8'h14, 5);
		{buffer[7], buffer[6], buffer[5], buffer[4]} = 32'h0001_0101;
		{buffer[3], buffer[2], buffer[1], buffer[0]} = 32'h0000_0999;
		wr(8'h00, 8);
		check({shared_irq_out_test_pin_oe_out, second_alarm_irq_output_oe_out}, 2'h0);
		osc_pulses(328);
		check({shared_irq_out_test_pin_oe_out, second_alarm_irq_output_oe_out}, 2'h3);
		// Clearing the flags must free both pins
		buffer[0] = 8'h00;
		wr(8'h0f, 1);
		ticks(3);
		check({shared_irq_out_test_pin_oe_out, second_alarm_irq_output_oe_out}, 2'h0);
		$display("t_alarm done");
	endtask
	// Test output must flip every half period of the oscillator divider
	task automatic t_freq_test;
		logic lvl;
		buffer[0] = 8'hc0;
		wr(8'h08, 1);
		ticks(3);
		lvl = shared_irq_out_test_pin_oe_out;
		check(shared_test_reset_pin_oe_out, lvl);
		osc_pulses(1 << (`RTC_FT_DIV_BITS - 1));
		check({shared_irq_out_test_pin_oe_out, shared_test_reset_pin_oe_out}, {2{!lvl}});
		osc_pulses(1 << (`RTC_FT_DIV_BITS - 1));
		check({shared_irq_out_test_pin_oe_out, shared_test_reset_pin_oe_out}, {2{lvl}});
		buffer[0] = 8'h80;
		wr(8'h08, 1);
		ticks(3);
		check({shared_irq_out_test_pin_oe_out, shared_test_reset_pin_oe_out}, 2'h0);
		$display("t_freq_test done");
	endtask
	initial begin
		ticks(20);
		resetn_in <= 1'b1;
		ticks(4);
		t_reset_map();
		t_square();
		t_wrong_addr();
		t_user_ram();
		t_rollover();
		t_supply_loss();
		t_out_bit();
		t_alarm();
		t_freq_test();
		wrap_up();
	end
	initial begin
		ticks(100000);
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
